// ### rtl/hmc_consts.vh
// constants for the haptic mode control register bank
// What this block does
// - soft reset bit seven acts like power cycle
// - soft reset stops playback, restores register defaults
// - soft reset bit clears itself afterwards
// - bit six standby, resets to one
// - mode bits two-zero; mode zero starts by software
// - mode one: trigger rising edge sets start
// - mode one: second rising edge while set cancels
// - mode two: start flag follows trigger level
// - mode two: falling edge cancels; matching state idle
// - mode three: trigger pin drives actuator continuously
// - mode three: input kind bit picks PWM/analog
// - mode four: audio on trigger pin becomes vibration
// - mode five drives realtime drive value register
// - mode six: start launches diagnostic, outcome stored
// - diagnostic done shown by start flag self-clearing
// - calibration done shown by start flag self-clearing
// - check outcome flag clears on read, last result
// - realtime value signed unless format bit set
`ifndef HMC_CONSTS_VH
`define HMC_CONSTS_VH
`define HMC_ADDR_STATUS     8'h00
`define HMC_ADDR_MODE       8'h01
`define HMC_ADDR_RTDRIVE    8'h02
`define HMC_ADDR_START      8'h0C
`define HMC_ADDR_CTRL3      8'h1D
`define HMC_BIT_RESET       7
`define HMC_BIT_STANDBY     6
`define HMC_BIT_CHECK       3
`define HMC_BIT_KIND        1
`define HMC_BIT_ACCOUPLE    5
`define HMC_BIT_FORMAT      3
`define HMC_MODE_RST        8'h40
`define HMC_MODE_WMASK      8'hC7
`define HMC_CTRL3_RST       8'h00
`define HMC_M_INTERNAL      3'h0
`define HMC_M_EDGE          3'h1
`define HMC_M_LEVEL         3'h2
`define HMC_M_PWM           3'h3
`define HMC_M_AUDIO         3'h4
`define HMC_M_REALTIME      3'h5
`define HMC_M_DIAG          3'h6
`define HMC_M_CAL           3'h7
`define HMC_RESET_CYCLES    4'h4
`endif

// ### rtl/hmc_trig_sync.v
// trigger pin synchroniser and edge detector
`timescale 1ns/1ps
`default_nettype none
module hmc_trig_sync (
  input  wire clk,
  input  wire rst_n,
  input  wire clk_en,
  input  wire pin_in,
  output wire level,
  output wire rise,
  output wire fall
);
  reg meta_q;   // first stage, read only by sync_q
  reg sync_q;   // synchronised level
  reg prev_q;   // delayed level for edges

  // two flop sync plus edge history
  always @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else if (clk_en) begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = clk_en & sync_q & ~prev_q;
  assign fall  = clk_en & ~sync_q & prev_q;
endmodule
`default_nettype wire

// ### rtl/hmc_mode_ctrl.v
// mode control register bank of the haptic driver
`timescale 1ns/1ps
`default_nettype none
`include "hmc_consts.vh"
module hmc_mode_ctrl (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       clk_en,
  // simple register port from the serial bus front end
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // trigger pin and engine handshakes
  input  wire       input_trigger_pin,
  input  wire       routine_done,
  input  wire       routine_fail,
  output reg        start_flag,
  output reg        cancel_pulse,
  output reg        soft_reset_active,
  output reg        standby,
  output reg  [2:0] op_mode,
  output reg        drive_from_pin,
  output reg        pin_is_analog,
  output reg        audio_mode,
  output reg        ac_coupling_enable,
  output reg        realtime_drive_en,
  output reg  [8:0] realtime_drive_out,
  output reg        diag_run,
  output reg        cal_run
);
  reg [7:0] mode_q;                 // operating_mode_control image
  reg [7:0] rtdrive_q;              // realtime drive value
  reg [7:0] ctrl3_q;                // kind, coupling and format bits
  reg       start_q;                // start flag
  reg       check_q;                // check outcome flag
  reg [3:0] rst_cnt_q;              // soft reset sequence counter
  reg       rst_busy_q;             // soft reset in progress

  wire      trig_level;
  wire      trig_rise;
  wire      trig_fall;
  wire [2:0] mode_sel = mode_q[2:0];
  wire      wr_mode = reg_wr & (reg_addr == `HMC_ADDR_MODE);
  wire      wr_start = reg_wr & (reg_addr == `HMC_ADDR_START);
  wire      rd_status = reg_rd & (reg_addr == `HMC_ADDR_STATUS);
  wire      kind_bit = ctrl3_q[`HMC_BIT_KIND];
  wire      fmt_bit = ctrl3_q[`HMC_BIT_FORMAT];

  // returns high when the mode uses the start flag as a routine launcher
  function is_self_clear;
    input [2:0] m;
    begin
      is_self_clear = (m == `HMC_M_DIAG) || (m == `HMC_M_CAL) ||
                      (m == `HMC_M_INTERNAL) || (m == `HMC_M_EDGE);
    end
  endfunction

  hmc_trig_sync u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .pin_in (input_trigger_pin),
    .level  (trig_level),
    .rise   (trig_rise),
    .fall   (trig_fall)
  );

  // soft reset sequencer: holds the configuration, start and check registers at default for a few cycles
  always @(posedge clk) begin
    if (!rst_n) begin
      rst_busy_q <= 1'b0;
      rst_cnt_q  <= 4'h0;
    end else if (clk_en) begin
      if (rst_busy_q) begin
        if (rst_cnt_q == `HMC_RESET_CYCLES) begin
          rst_busy_q <= 1'b0;
          rst_cnt_q  <= 4'h0;
        end else begin
          rst_cnt_q <= rst_cnt_q + 4'h1;
        end
      end else if (wr_mode && reg_wdata[`HMC_BIT_RESET]) begin
        rst_busy_q <= 1'b1;
        rst_cnt_q  <= 4'h0;
      end
    end
  end

  // configuration registers; all return to defaults during soft reset
  always @(posedge clk) begin
    if (!rst_n) begin
      mode_q    <= `HMC_MODE_RST;
      rtdrive_q <= 8'h00;
      ctrl3_q   <= `HMC_CTRL3_RST;
    end else if (clk_en) begin
      if (rst_busy_q) begin
        mode_q    <= `HMC_MODE_RST;
        rtdrive_q <= 8'h00;
        ctrl3_q   <= `HMC_CTRL3_RST;
      end else if (reg_wr) begin
        case (reg_addr)
          `HMC_ADDR_MODE: begin
            mode_q <= reg_wdata & `HMC_MODE_WMASK;
          end
          `HMC_ADDR_RTDRIVE: begin
            rtdrive_q <= reg_wdata;
          end
          `HMC_ADDR_CTRL3: begin
            ctrl3_q <= reg_wdata;
          end
          default: begin
            mode_q <= mode_q;
          end
        endcase
      end
    end
  end

  // start flag: software, trigger pin and engine completion
  always @(posedge clk) begin
    if (!rst_n) begin
      start_q      <= 1'b0;
      cancel_pulse <= 1'b0;
    end else if (clk_en) begin
      cancel_pulse <= 1'b0;
      if (rst_busy_q) begin
        start_q      <= 1'b0;
        cancel_pulse <= start_q;
      end else begin
        case (mode_sel)
          `HMC_M_EDGE: begin
            if (trig_rise && start_q) begin
              start_q      <= 1'b0;
              cancel_pulse <= 1'b1;
            end else if (trig_rise) begin
              start_q <= 1'b1;
            end else if (wr_start) begin
              start_q <= reg_wdata[0];
            end else if (routine_done) begin
              start_q <= 1'b0;
            end
          end
          `HMC_M_LEVEL: begin
            if (trig_rise && !start_q) begin
              start_q <= 1'b1;
            end else if (trig_fall && start_q) begin
              start_q      <= 1'b0;
              cancel_pulse <= 1'b1;
            end else if (wr_start) begin
              start_q <= reg_wdata[0];
            end
          end
          default: begin
            if (wr_start) begin
              start_q <= reg_wdata[0];
            end else if (routine_done && is_self_clear(mode_sel)) begin
              start_q <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // check outcome flag: set by completion, cleared by status read
  always @(posedge clk) begin
    if (!rst_n) begin
      check_q <= 1'b0;
    end else if (clk_en) begin
      if (rst_busy_q) begin
        check_q <= 1'b0;
      // outcome stored on completion, wins over read clear
      end else if (routine_done && start_q &&
                   (mode_sel == `HMC_M_DIAG || mode_sel == `HMC_M_CAL)) begin
        check_q <= routine_fail;
      end else if (rd_status) begin
        check_q <= 1'b0;
      end
    end
  end

  // read data mux, registered
  always @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      case (reg_addr)
        `HMC_ADDR_STATUS:  reg_rdata <= {4'h0, check_q, 3'h0};
        // reset bit reads back while busy only
        `HMC_ADDR_MODE:    reg_rdata <= {rst_busy_q, mode_q[6:0]};
        `HMC_ADDR_RTDRIVE: reg_rdata <= rtdrive_q;
        `HMC_ADDR_START:   reg_rdata <= {7'h00, start_q};
        `HMC_ADDR_CTRL3:   reg_rdata <= ctrl3_q;
        default:           reg_rdata <= 8'h00;
      endcase
    end
  end

  // engine-facing outputs, all registered
  always @(posedge clk) begin
    if (!rst_n) begin
      start_flag         <= 1'b0;
      soft_reset_active  <= 1'b0;
      standby            <= 1'b1;
      op_mode            <= 3'h0;
      drive_from_pin     <= 1'b0;
      pin_is_analog      <= 1'b0;
      audio_mode         <= 1'b0;
      ac_coupling_enable <= 1'b0;
      realtime_drive_en  <= 1'b0;
      realtime_drive_out <= 9'h000;
      diag_run           <= 1'b0;
      cal_run            <= 1'b0;
    end else if (clk_en) begin
      start_flag        <= start_q;
      soft_reset_active <= rst_busy_q;
      standby           <= mode_q[`HMC_BIT_STANDBY];
      op_mode           <= mode_sel;
      drive_from_pin    <= (mode_sel == `HMC_M_PWM) && !rst_busy_q;
      pin_is_analog     <= kind_bit;
      audio_mode        <= (mode_sel == `HMC_M_AUDIO) && !rst_busy_q;
      ac_coupling_enable <= ctrl3_q[`HMC_BIT_ACCOUPLE];
      realtime_drive_en <= (mode_sel == `HMC_M_REALTIME) && !rst_busy_q;
      realtime_drive_out <= fmt_bit ? {1'b0, rtdrive_q} :
                                      {rtdrive_q[7], rtdrive_q};
      diag_run          <= (mode_sel == `HMC_M_DIAG) && start_q;
      cal_run           <= (mode_sel == `HMC_M_CAL) && start_q;
    end
  end
endmodule
`default_nettype wire

// ### verif/hmc_engine_model.sv
// playback engine stand-in that finishes routines after a set delay
`timescale 1ns/1ps
`default_nettype none
module hmc_engine_model (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic       fail,
  input  wire logic [7:0] dly,
  output var  logic       done = 1'h0,
  output wire logic       fail_o
);
  logic [8:0] cnt_q = 9'h000;  // cycles since start rose
  // zero delay means the engine stalls and never finishes
  always @(posedge clk) begin
    done <= 1'h0;
    if (!start || dly == 8'h00) begin
      cnt_q <= 9'h000;
    end else if (cnt_q < {1'h0, dly}) begin
      cnt_q <= cnt_q + 9'h001;
    end else if (cnt_q == {1'h0, dly}) begin
      done  <= 1'h1;
      cnt_q <= cnt_q + 9'h001;
    end
  end
  // outcome is only meaningful with done, so show garbage otherwise
  assign fail_o = done ? fail : ~fail;
endmodule
`default_nettype wire

// ### verif/hmc_mode_ctrl_sva.sv
// checker for the mode control register bank
`timescale 1ns/1ps
`default_nettype none
module hmc_mode_ctrl_sva (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic       input_trigger_pin,
  input wire logic       start_flag,
  input wire logic       cancel_pulse,
  input wire logic       soft_reset_active,
  input wire logic       standby,
  input wire logic [2:0] op_mode,
  input wire logic       drive_from_pin,
  input wire logic       realtime_drive_en,
  input wire logic       diag_run,
  input wire logic       cal_run
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_resv; reg_addr == 8'h01 |=> reg_rdata[5:3] == 3'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved mode bits nonzero");
  property p_sr_len; $rose(soft_reset_active) |-> soft_reset_active[*5] ##1 !soft_reset_active;
  endproperty
  a_sr_len: assert property (p_sr_len) else $error("soft reset length wrong");
  property p_sr_def; $fell(soft_reset_active) |-> standby && op_mode == 3'h0 && !start_flag;
  endproperty
  a_sr_def: assert property (p_sr_def) else $error("defaults missing after reset");
  property p_sr_stop; soft_reset_active[*3] |-> !start_flag; endproperty
  a_sr_stop: assert property (p_sr_stop) else $error("playback kept in reset");
  property p_trig; $rose(input_trigger_pin) && op_mode == 3'h1 && !start_flag && !standby
    && !soft_reset_active |-> ##[2:5] start_flag; endproperty
  a_trig: assert property (p_trig) else $error("edge did not start");
  property p_can; cancel_pulse |=> !cancel_pulse; endproperty
  a_can: assert property (p_can) else $error("cancel longer than one cycle");
  property p_diag; diag_run |-> op_mode == 3'h6 && start_flag; endproperty
  a_diag: assert property (p_diag) else $error("diagnostic run wrong");
  property p_cal; cal_run |-> op_mode == 3'h7 && start_flag; endproperty
  a_cal: assert property (p_cal) else $error("calibration run wrong");
  property p_rt; realtime_drive_en |-> op_mode == 3'h5; endproperty
  a_rt: assert property (p_rt) else $error("realtime drive outside mode");
  property p_pin; drive_from_pin |-> op_mode == 3'h3; endproperty
  a_pin: assert property (p_pin) else $error("pin drive outside mode");
endmodule
bind hmc_mode_ctrl hmc_mode_ctrl_sva u_sva (.clk, .rst_n, .reg_addr, .reg_rdata,
  .input_trigger_pin, .start_flag, .cancel_pulse, .soft_reset_active, .standby, .op_mode,
  .drive_from_pin, .realtime_drive_en, .diag_run, .cal_run);
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for the mode control register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk = 0, rst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, input_trigger_pin = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, dly = 8'h00, q;
  logic       routine_done, routine_fail, fail = 0, start_flag, cancel_pulse;
  logic       soft_reset_active, standby, drive_from_pin, pin_is_analog, audio_mode;
  logic       ac_coupling_enable, realtime_drive_en, diag_run, cal_run;
  logic [2:0] op_mode;
  logic [8:0] realtime_drive_out;
  int         n_errors = 0, samples_checked = 0, cyc = 0, n_cancel = 0, m;
  always #5 clk = ~clk;
  hmc_mode_ctrl DUT (.clk, .rst_n, .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .input_trigger_pin, .routine_done, .routine_fail, .start_flag, .cancel_pulse,
    .soft_reset_active, .standby, .op_mode, .drive_from_pin, .pin_is_analog, .audio_mode,
    .ac_coupling_enable, .realtime_drive_en, .realtime_drive_out, .diag_run, .cal_run);
  hmc_engine_model ENG (.clk, .start(start_flag), .fail, .dly, .done(routine_done),
    .fail_o(routine_fail));
  // cycle ceiling and cancel counting
  always @(posedge clk) begin
    cyc++;
    if (cancel_pulse === 1'b1) n_cancel++;
    if (cyc == 3000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one-cycle strobes, driven between edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk); reg_addr = a; reg_wdata = d; reg_wr = 1;
    @(negedge clk); reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk); reg_addr = a; reg_rd = 1;
    @(negedge clk); reg_rd = 0; q = reg_rdata;
  endtask
  task automatic trig(input logic v);
    @(negedge clk); input_trigger_pin = v;
    repeat (6) @(negedge clk);
  endtask
  task close_out;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    rd(8'h01); chk(q, 8'h40);
    chk(standby, 1'h1);
    rd(8'h55); chk(q, 8'h00);
    wr(8'h01, 8'h3F); rd(8'h01); chk(q, 8'h07);
    $display("test defaults done");
    // software start, diagnostic with fault, calibration passing
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 0 : i + 5;
      fail = (m == 6);
      dly = 8'h04;
      wr(8'h01, m[7:0]); wr(8'h0C, 8'h01);
      @(negedge clk); chk(start_flag, 1'h1);
      chk(op_mode, m[2:0]);
      chk(diag_run, m == 6);
      chk(cal_run, m == 7);
      repeat (8) @(negedge clk); chk(start_flag, 1'h0);
      if (m != 0) begin
        rd(8'h00); chk(q[3], fail);
        rd(8'h00); chk(q[3], 1'h0);
      end
    end
    $display("test routines done");
    dly = 8'h00; n_cancel = 0;
    wr(8'h01, 8'h01); trig(1); chk(start_flag, 1'h1);
    trig(0); trig(1); chk(start_flag, 1'h0); chk(n_cancel, 9'h001);
    trig(0); wr(8'h01, 8'h02); trig(1); chk(start_flag, 1'h1);
    trig(0); chk(start_flag, 1'h0); chk(n_cancel, 9'h002);
    $display("test trigger done");
    wr(8'h1D, 8'h22); wr(8'h01, 8'h03); repeat (2) @(negedge clk);
    chk({drive_from_pin, pin_is_analog}, 2'h3);
    wr(8'h01, 8'h04); repeat (2) @(negedge clk);
    chk({audio_mode, ac_coupling_enable}, 2'h3);
    wr(8'h02, 8'h80); wr(8'h01, 8'h05); repeat (2) @(negedge clk);
    chk(realtime_drive_en, 1'h1);
    chk(realtime_drive_out, 9'h180);
    wr(8'h1D, 8'h08); repeat (2) @(negedge clk); chk(realtime_drive_out, 9'h080);
    $display("test drive modes done");
    wr(8'h01, 8'h07); wr(8'h0C, 8'h01); repeat (2) @(negedge clk);
    wr(8'h01, 8'h80); @(negedge clk); chk(soft_reset_active, 1'h1);
    rd(8'h01); chk(q, 8'hC0);
    repeat (8) @(negedge clk); chk(start_flag, 1'h0); chk(n_cancel, 9'h003);
    chk(standby, 1'h1);
    rd(8'h01); chk(q, 8'h40);
    rd(8'h02); chk(q, 8'h00);
    rd(8'h1D); chk(q, 8'h00);
    $display("test soft reset done");
    close_out();
  end
endmodule
`default_nettype wire
